// ---- rtl/atcs_params.svh ----
// Constants for the arbitrary-board trigger and clock select block.
// Assumes a single 200 MHz clock and an active-low asynchronous reset.
//
// Contract
// - High internal_n passes comparator trigger; low lets choice decide.
// - Internal: choice low picks square logic, high picks divider clock out.
// - Low sequencer counter clear line clears the state counter.
// - Stop flag high at stop address; complement low there.
// - Source enable low forces run high; pulse low needs both enables.
// - Override high picks decoder strobe as phase clock; else alt choice.
// - Low trigger block line inhibits the state machine trigger circuit.
// - Oscillator shutdown high stops the oscillator; low lets it run.
// - Each control register latches data on its own strobe's rising edge.
// - Active-low bank enable; its two registers respond only while low.
// - Wave memory output enabled only while memory enable line is low.
// - Low slow slew select chooses slow slew rate.
// - Breakpoint flag high at each programmed breakpoint address.
// - Accumulator drives memory address; registers supply its preset.
// - Divider counts while run high; cleared while run low. The code holds it while oscillator shutdown is high.
// - Override low: alt choice low clocks from divider, high from trigger.
`ifndef ATCS_PARAMS_SVH
`define ATCS_PARAMS_SVH
`define ATCS_ADDR_W     13
`define ATCS_DIV_W      16
`define ATCS_NREG       15
// Register index map (strobe number)
`define ATCS_R_PRESET_LO 0
`define ATCS_R_PRESET_HI 1
`define ATCS_R_CTRL_A    2
`define ATCS_R_CTRL_B    4
`define ATCS_R_BANK0     13
`define ATCS_R_BANK1     14
// Control A bit positions
`define ATCS_B_INT_N     0
`define ATCS_B_CHOICE    1
`define ATCS_B_CLR_N     2
`define ATCS_B_FSE       3
`define ATCS_B_SYNC      4
`define ATCS_B_OVR       5
`define ATCS_B_ALT       6
`define ATCS_B_VCO       7
// Control B bit positions
`define ATCS_B_MEM_EN_N  0
`define ATCS_B_SLEW_N    1
`define ATCS_B_TRIG_BLK  2
// Safe reset values: memory off, oscillator off, trigger blocked
`define ATCS_RST_CTRL_A  8'h84
`define ATCS_RST_CTRL_B  8'h07
`define ATCS_RST_DATA    8'h00
`endif

// ---- rtl/atcs_pkg.sv ----
// Types for the trigger and clock select block.
// Assumes atcs_params.svh for all numbers.
`include "atcs_params.svh"
package atcs_pkg;
    typedef logic [7:0]                 atcs_byte_t;
    typedef logic [`ATCS_ADDR_W-1:0]    atcs_addr_t;
    typedef logic [`ATCS_NREG-1:0]      atcs_strobes_t;
    typedef enum logic [1:0] {
        ATCS_PH_DIVIDER,
        ATCS_PH_TRIG,
        ATCS_PH_DECODE
    } atcs_phsrc_t;
endpackage

// ---- rtl/atcs_trigger_clock_select.sv ----
// Control registers, trigger and phase clock selection, divider,
// phase accumulator and wave memory flags of the arbitrary board.
// Assumes strobes and board signals arrive asynchronously to i_clock.
`timescale 1ns/1ps
`include "atcs_params.svh"
module atcs_trigger_clock_select (
    // Clock and reset
    input  wire logic                    i_clock,
    input  wire logic                    i_resetn,
    input  wire logic                    i_clk_en,
    // Processor side
    input  wire atcs_pkg::atcs_byte_t    i_data,
    input  wire atcs_pkg::atcs_strobes_t i_reg_strobe,
    input  wire logic                    i_bank_enable_n,
    // Board signals in
    input  wire logic                    i_comparator_trigger,
    input  wire logic                    i_square_logic,
    input  wire logic                    i_trigger_request,
    input  wire logic                    i_trigger_block_n,
    input  wire logic                    i_phase_step,
    input  wire logic                    i_preset_load,
    input  wire logic                    i_state_step,
    input  wire atcs_pkg::atcs_addr_t    i_stop_address,
    input  wire atcs_pkg::atcs_addr_t    i_breakpoint_address,
    input  wire logic [15:0]             i_divide_ratio,
    // Outputs
    output logic                         o_selected_trigger_buffered,
    output logic                         o_divider_clock_out,
    output logic                         o_divider_run,
    output atcs_pkg::atcs_phsrc_t        o_phase_source,
    output logic                         o_phase_clock,
    output atcs_pkg::atcs_addr_t         o_wave_memory_address,
    output atcs_pkg::atcs_addr_t         o_accumulator_preset,
    output logic                         o_end_flag,
    output logic                         o_end_flag_n,
    output logic                         o_breakpoint_flag,
    output logic                         o_wave_memory_enable,
    output logic                         o_slow_slew_select_n,
    output logic                         o_oscillator_shutdown,
    output logic                         o_trigger_inhibited,
    output logic [3:0]                   o_state_count
);
    import atcs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers; first stage read only by the second
    localparam int SW = `ATCS_NREG + 6;
    logic [SW-1:0] sync1_ff;
    logic [SW-1:0] sync2_ff;
    logic [SW-1:0] sync3_ff;
    atcs_byte_t    data1_ff;
    atcs_byte_t    data2_ff;
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
            data1_ff <= '0;
            data2_ff <= '0;
        end else if (i_clk_en) begin
            sync1_ff <= {i_reg_strobe, i_bank_enable_n, i_comparator_trigger,
                         i_square_logic, i_trigger_request,
                         i_trigger_block_n, i_phase_step};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            // Same depth as the strobes, so data is valid at the latch edge
            data1_ff <= i_data;
            data2_ff <= data1_ff;
        end
    end
    logic          bank_n_s;
    logic          cmp_s;
    logic          sq_s;
    logic          trq_s;
    logic          blk_n_s;
    logic          step_s;
    atcs_strobes_t strobe_rise;
    assign bank_n_s = sync2_ff[5];
    assign cmp_s    = sync2_ff[4];
    assign sq_s     = sync2_ff[3];
    assign trq_s    = sync2_ff[2] & ~sync3_ff[2];
    assign blk_n_s  = sync2_ff[1];
    assign step_s   = sync2_ff[0] & ~sync3_ff[0];
    assign strobe_rise = sync2_ff[SW-1:6] & ~sync3_ff[SW-1:6];

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    atcs_byte_t regs_ff [`ATCS_NREG];
    function automatic logic in_bank(input int idx);
        return idx == `ATCS_R_BANK0 || idx == `ATCS_R_BANK1;
    endfunction
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int k = 0; k < `ATCS_NREG; k++) begin
                regs_ff[k] <= `ATCS_RST_DATA;
            end
            regs_ff[`ATCS_R_CTRL_A] <= `ATCS_RST_CTRL_A;
            regs_ff[`ATCS_R_CTRL_B] <= `ATCS_RST_CTRL_B;
        end else if (i_clk_en) begin
            for (int k = 0; k < `ATCS_NREG; k++) begin
                if (strobe_rise[k] && (!in_bank(k) || !bank_n_s)) begin
                    regs_ff[k] <= data2_ff;
                end
            end
        end
    end
    atcs_byte_t ca;
    atcs_byte_t cb;
    assign ca = regs_ff[`ATCS_R_CTRL_A];
    assign cb = regs_ff[`ATCS_R_CTRL_B];

    ////////////////////////////////////////////////////////////////////////
    // Trigger selection
    logic trig_nxt;
    always_comb begin
        if (ca[`ATCS_B_INT_N]) begin
            trig_nxt = cmp_s;
        end else if (ca[`ATCS_B_CHOICE]) begin
            trig_nxt = o_divider_clock_out;
        end else begin
            trig_nxt = sq_s;
        end
    end
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_selected_trigger_buffered <= 1'b0;
        end else if (i_clk_en) begin
            o_selected_trigger_buffered <= trig_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger circuit and divider run
    logic inhibit;
    assign inhibit = !blk_n_s || cb[`ATCS_B_TRIG_BLK];
    assign o_trigger_inhibited = inhibit;
    logic run_pulse_n;
    assign run_pulse_n = !(trq_s && !inhibit);
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_divider_run <= 1'b1;
        end else if (i_clk_en) begin
            o_divider_run <= !ca[`ATCS_B_FSE] || !ca[`ATCS_B_SYNC]
                             || run_pulse_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Programmable divider; oscillator shutdown freezes it while run is high
    logic [`ATCS_DIV_W-1:0] div_ff;
    assign o_oscillator_shutdown = ca[`ATCS_B_VCO];
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            div_ff              <= '0;
            o_divider_clock_out <= 1'b0;
        end else if (i_clk_en) begin
            if (!o_divider_run) begin
                div_ff              <= '0;
                o_divider_clock_out <= 1'b0;
            end else if (!o_oscillator_shutdown) begin
                if (div_ff >= i_divide_ratio) begin
                    div_ff              <= '0;
                    o_divider_clock_out <= ~o_divider_clock_out;
                end else begin
                    div_ff <= div_ff + 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase clock selection
    atcs_phsrc_t src;
    logic        ph_nxt;
    always_comb begin
        if (ca[`ATCS_B_OVR]) begin
            src    = ATCS_PH_DECODE;
            ph_nxt = step_s;
        end else if (ca[`ATCS_B_ALT]) begin
            src    = ATCS_PH_TRIG;
            ph_nxt = o_selected_trigger_buffered;
        end else begin
            src    = ATCS_PH_DIVIDER;
            ph_nxt = o_divider_clock_out;
        end
    end
    logic ph_prev_ff;
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_phase_source <= ATCS_PH_DIVIDER;
            o_phase_clock  <= 1'b0;
            ph_prev_ff     <= 1'b0;
        end else if (i_clk_en) begin
            o_phase_source <= src;
            o_phase_clock  <= ph_nxt;
            ph_prev_ff     <= o_phase_clock;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase accumulator and wave memory flags
    atcs_addr_t preset;
    assign preset = {regs_ff[`ATCS_R_PRESET_HI][4:0],
                     regs_ff[`ATCS_R_PRESET_LO]};
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_wave_memory_address <= '0;
            o_accumulator_preset  <= '0;
        end else if (i_clk_en) begin
            o_accumulator_preset <= preset;
            if (i_preset_load) begin
                o_wave_memory_address <= preset;
            end else if (o_phase_clock && !ph_prev_ff) begin
                o_wave_memory_address <= o_wave_memory_address + 1'b1;
            end
        end
    end
    assign o_end_flag   = o_wave_memory_address == i_stop_address;
    assign o_end_flag_n = ~o_end_flag;
    assign o_breakpoint_flag =
        o_wave_memory_address == i_breakpoint_address;
    assign o_wave_memory_enable = !cb[`ATCS_B_MEM_EN_N];
    assign o_slow_slew_select_n = cb[`ATCS_B_SLEW_N];

    ////////////////////////////////////////////////////////////////////////
    // State counter
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_state_count <= 4'h0;
        end else if (i_clk_en) begin
            if (!ca[`ATCS_B_CLR_N]) begin
                o_state_count <= 4'h0;
            end else if (i_state_step && !inhibit) begin
                o_state_count <= o_state_count + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_run_low;
        !o_divider_run;
    endsequence
    a_run_forced_high: assert property (@(posedge i_clock)
        disable iff (!i_resetn)
        i_clk_en && !ca[`ATCS_B_FSE] |=> o_divider_run)
        else $error("divider run low with source disabled");
    a_div_cleared: assert property (@(posedge i_clock)
        disable iff (!i_resetn)
        s_run_low ##0 i_clk_en |=> div_ff == '0)
        else $error("divider not cleared");
    a_clear_state: assert property (@(posedge i_clock)
        disable iff (!i_resetn)
        i_clk_en && !ca[`ATCS_B_CLR_N] |=> o_state_count == 4'h0)
        else $error("state counter not cleared");
    a_trig_ext: assert property (@(posedge i_clock)
        disable iff (!i_resetn)
        i_clk_en && ca[`ATCS_B_INT_N] |=>
        o_selected_trigger_buffered == $past(cmp_s))
        else $error("comparator trigger not passed");
    a_trig_int: assert property (@(posedge i_clock)
        disable iff (!i_resetn)
        i_clk_en && !ca[`ATCS_B_INT_N] && !ca[`ATCS_B_CHOICE] |=>
        o_selected_trigger_buffered == $past(sq_s))
        else $error("square logic not passed");
    a_phase_over: assert property (@(posedge i_clock)
        disable iff (!i_resetn)
        i_clk_en && ca[`ATCS_B_OVR] |=> o_phase_source == ATCS_PH_DECODE)
        else $error("override not honoured");
    a_phase_alt: assert property (@(posedge i_clock)
        disable iff (!i_resetn)
        i_clk_en && !ca[`ATCS_B_OVR] && ca[`ATCS_B_ALT] |=>
        o_phase_source == ATCS_PH_TRIG)
        else $error("alternate clock not chosen");
    a_inhibit_hold: assert property (@(posedge i_clock)
        disable iff (!i_resetn)
        i_clk_en && inhibit && ca[`ATCS_B_CLR_N] |=>
        o_state_count == $past(o_state_count))
        else $error("state moved while inhibited");
    a_preset_load: assert property (@(posedge i_clock)
        disable iff (!i_resetn)
        i_clk_en && i_preset_load |=> o_wave_memory_address == $past(preset))
        else $error("preset not loaded");
endmodule // atcs_trigger_clock_select

// ---- verif/atcs_cpu_model.sv ----
// Board processor model that writes the strobed control registers.
// Assumes the block samples strobes and data on i_clock.
`timescale 1ns/1ps
module atcs_cpu_model (
    // Clock
    input  wire logic               i_clock,
    // Register write side
    output atcs_pkg::atcs_byte_t    o_data,
    output atcs_pkg::atcs_strobes_t o_reg_strobe,
    output logic                    o_bank_enable_n
);
    import atcs_pkg::*;
    logic bank_block;
    ////////////////////////////////////////////////////////////////////
    initial begin
        o_data = 8'h5a;
        o_reg_strobe = '0;
        o_bank_enable_n = 1'b1;
        bank_block = 1'b0;
    end
    // Keeps the bank enable high so bank writes must be refused
    task automatic block_bank(input logic v);
        bank_block = v;
    endtask
    ////////////////////////////////////////////////////////////////////
    // Data is released to its inverse once the hold time has run out,
    // so a register that latches late shows a wrong value
    task automatic write_reg(input int idx, input atcs_byte_t val);
        @(negedge i_clock);
        o_data = val;
        o_bank_enable_n = (idx < 13) || bank_block;
        o_reg_strobe[idx] = 1'b1;
        repeat (3) @(negedge i_clock);
        o_reg_strobe[idx] = 1'b0;
        repeat (2) @(negedge i_clock);
        o_data = ~val;
        o_bank_enable_n = 1'b1;
        repeat (4) @(negedge i_clock);
    endtask
endmodule // atcs_cpu_model

// ---- verif/arb_trigger_clock_select_tb_top.sv ----
// Self-checking bench for the trigger and clock select block.
// Assumes the processor model drives every register strobe.
`timescale 1ns/1ps
module arb_trigger_clock_select_tb_top;
    import atcs_pkg::*;
    ////////////////////////////////////////////////////////////////////
    logic          clk, rst_n, comp, sq, treq, tblk_n, pload, sstep;
    atcs_byte_t    data, bank_reg;
    atcs_strobes_t strb;
    logic          bank_n, trig, dclk, drun, pclk, endf, endf_n, bkf;
    logic          memen, slew_n, vco, inhib, pstep, ce, dprev;
    atcs_phsrc_t   psrc;
    atcs_addr_t    stop, bkpt, addr, pre, pe;
    logic [3:0]    scnt, ec;
    logic [7:0]    a, r0, r1;
    logic [31:0]   rs = 32'h040d;
    int            err_count, checked, n;
    // Divider half period is this ratio plus one clock
    localparam logic [15:0] DIV_RATIO = 16'h0003;
    assign bank_reg = u_atcs_trigger_clock_select.regs_ff[13];
    ////////////////////////////////////////////////////////////////////
    atcs_cpu_model u_atcs_cpu_model (.i_clock(clk), .o_data(data),
        .o_reg_strobe(strb), .o_bank_enable_n(bank_n));
    atcs_trigger_clock_select u_atcs_trigger_clock_select (
        .i_clock(clk), .i_resetn(rst_n), .i_clk_en(ce),
        .i_data(data), .i_reg_strobe(strb), .i_bank_enable_n(bank_n),
        .i_comparator_trigger(comp), .i_square_logic(sq),
        .i_trigger_request(treq), .i_trigger_block_n(tblk_n),
        .i_phase_step(pstep), .i_preset_load(pload),
        .i_state_step(sstep), .i_stop_address(stop),
        .i_breakpoint_address(bkpt), .i_divide_ratio(DIV_RATIO),
        .o_selected_trigger_buffered(trig), .o_divider_clock_out(dclk),
        .o_divider_run(drun), .o_phase_source(psrc),
        .o_phase_clock(pclk), .o_wave_memory_address(addr),
        .o_accumulator_preset(pre), .o_end_flag(endf),
        .o_end_flag_n(endf_n), .o_breakpoint_flag(bkf),
        .o_wave_memory_enable(memen), .o_slow_slew_select_n(slew_n),
        .o_oscillator_shutdown(vco), .o_trigger_inhibited(inhib),
        .o_state_count(scnt));
    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    function automatic atcs_phsrc_t exp_src(input logic [7:0] v);
        if (v[5]) return ATCS_PH_DECODE;
        return v[6] ? ATCS_PH_TRIG : ATCS_PH_DIVIDER;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string m);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic give_verdict();
        $display("checked %0d, errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Whole run is about 950 cycles; the limit leaves wide margin
    initial begin
        #200us;
        err_count++;
        give_verdict();
    end
    initial begin
        rst_n = 1'b0;
        {comp, sq, treq, tblk_n, pload, sstep, pstep} = '0;
        ce = 1'b1;
        stop = '0;
        bkpt = '0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        chk(memen, 1'b0, "memory enabled at reset");
        chk(slew_n, 1'b1, "slew select at reset");
        chk(vco, 1'b1, "oscillator at reset");
        chk(drun, 1'b1, "divider run at reset");
        chk(inhib, 1'b1, "trigger not inhibited");
        tblk_n = 1'b1;
        repeat (3) @(negedge clk);
        chk(inhib, 1'b1, "trigger free before first write");
        for (int b = 0; b < 4; b++) begin
            u_atcs_cpu_model.write_reg(4, 8'(b));
            chk(memen, !b[0], "memory enable");
            chk(slew_n, b[1], "slew select");
        end
        u_atcs_cpu_model.write_reg(13, 8'h3c);
        chk(bank_reg, 8'h3c, "bank write");
        u_atcs_cpu_model.block_bank(1'b1);
        u_atcs_cpu_model.write_reg(13, 8'hc3);
        u_atcs_cpu_model.block_bank(1'b0);
        chk(bank_reg, 8'h3c, "bank write not refused");
        ec = 4'h0;
        for (int i = 0; i < 16; i++) begin
            a = 8'(rnd());
            if (i < 8) begin
                a[3:0] = {2'b00, i[1:0]};
                a[6:5] = i[2:1];
            end
            comp = rs[8];
            sq = rs[9];
            tblk_n = (i < 8) || rs[10];
            u_atcs_cpu_model.write_reg(2, a);
            repeat (4) @(negedge clk);
            chk(16'(psrc), 16'(exp_src(a)), "phase source");
            chk(vco, a[7], "oscillator shutdown");
            chk(inhib, !tblk_n, "trigger inhibit");
            if (a[0] || !a[1]) begin
                chk(trig, a[0] ? comp : sq, "trigger");
                if (!a[5] && a[6])
                    chk(pclk, a[0] ? comp : sq, "phase clock");
            end
            if (a[5]) begin
                pstep = 1'b1;
                n = 0;
                repeat (6) begin
                    @(negedge clk);
                    n += int'(pclk);
                end
                pstep = 1'b0;
                chk(16'(n), 16'h0001, "decoder strobe");
            end
            treq = 1'b1;
            n = 0;
            repeat (6) begin
                @(negedge clk);
                n += int'(!drun);
                if (!a[3]) chk(drun, 1'b1, "divider run dropped");
            end
            treq = 1'b0;
            chk(16'(n), 16'(a[3] && a[4] && tblk_n), "run pulse");
            sstep = 1'b1;
            repeat (3) @(negedge clk);
            sstep = 1'b0;
            @(negedge clk);
            if (!a[2]) ec = 4'h0;
            else if (tblk_n) ec = ec + 4'h3;
            chk(scnt, ec, "state count not cleared");
            n = 0;
            repeat (16) begin
                dprev = dclk;
                @(negedge clk);
                n += int'(dclk != dprev);
            end
            chk(16'(n), a[7] ? 16'h0000 : 16'(16 / (DIV_RATIO + 1)),
                "divider clock");
        end
        pload = 1'b1;
        for (int i = 0; i < 8; i++) begin
            r0 = (i == 0) ? 8'hff : 8'(rnd());
            r1 = (i == 0) ? 8'hff : 8'(rnd());
            pe = {r1[4:0], r0};
            u_atcs_cpu_model.write_reg(0, r0);
            u_atcs_cpu_model.write_reg(1, r1);
            chk(pre, pe, "preset value");
            chk(addr, pe, "address from preset");
            stop = pe ^ 13'(i[0]);
            bkpt = pe ^ 13'(i[1]);
            @(negedge clk);
            chk(endf, !i[0], "stop flag");
            chk(endf_n, i[0], "stop flag complement");
            chk(bkf, !i[1], "breakpoint flag");
        end
        // A strobe seen only while the clock enable is low must be lost
        ce = 1'b0;
        u_atcs_cpu_model.write_reg(0, ~r0);
        ce = 1'b1;
        repeat (4) @(negedge clk);
        chk(pre, pe, "register moved while frozen");
        give_verdict();
    end
endmodule // arb_trigger_clock_select_tb_top
